/* common/dsi_rx_pkg.sv */
// constants and types for the sensor-bus receive check block
package dsi_rx_pkg;
   localparam int NCH = 4;
   localparam int MSG_W = 16;
   localparam int CRC_MAX = 8;
   localparam int FUSE_N = 128;
   localparam int PARITY_ERR_BIT = 7;
   localparam logic [3:0] DEF_CRC_LEN = 4'h4;
   localparam logic [7:0] DEF_POLY = 8'h11;
   localparam logic [7:0] DEF_SEED = 8'h0a;
   localparam int DATA_LSB = 0;
   localparam int DATA_W = 8;
   localparam int ADDR_LSB = 8;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_ALL1 = 8'hff;
   localparam logic [7:0] ADDR_ALL0 = 8'h00;
   localparam int P_HIGH = 0;
   localparam int P_LOW = 1;
   localparam int P_SUM0 = 2;
   localparam int P_SUM1 = 3;
   localparam int NPATH = 4;
   localparam logic [6:0] MASK_REV_DEF = 7'h15;

   typedef struct packed {
      logic [3:0] len;
      logic [7:0] poly;
      logic [7:0] seed;
   } crc_cfg_t;

   typedef struct packed {
      logic start;
      logic valid;
      logic fin;
      logic high;
      logic low;
      logic sum;
      logic tx;
      logic fault;
   } lane_t;

   typedef struct packed {
      logic err;
      logic main_sum;
      logic ro_sum;
   } dec_t;

   typedef enum logic [1:0] {
      FS_LOAD = 2'b01,
      FS_DONE = 2'b10
   } fuse_st_t;
endpackage

/* src/rx_crc_path.sv */
// one serial receive path: shift register plus programmable crc check
`timescale 1ns/10ps
`default_nettype none
module rx_crc_path
   import dsi_rx_pkg::*;
#(
   parameter int W = MSG_W
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_start,
   input wire logic i_valid,
   input wire logic i_fin,
   input wire logic i_bit,
   input wire crc_cfg_t i_cfg,
   output logic [W-1:0] o_data,
   output logic o_crc_ok,
   output logic o_done
);
   typedef struct packed {
      logic [CRC_MAX-1:0] crc;
      logic [W+CRC_MAX-1:0] sh;
      logic [W-1:0] data;
      logic ok;
      logic done;
   } path_st_t;

   path_st_t st;
   path_st_t next_st;

   if (W < 1) begin : g_chk
      $error("rx_crc_path: width must be positive");
   end

   function automatic logic [CRC_MAX-1:0] len_mask(input logic [3:0] len);
      logic [CRC_MAX-1:0] m;
      m = '0;
      for (int i = 0; i < CRC_MAX; i++) begin
         m[i] = (4'(i) < len);
      end
      return m;
   endfunction

   always_comb begin
      logic [CRC_MAX-1:0] m;
      logic fb;
      m = len_mask(i_cfg.len);
      fb = 1'b0;
      next_st = st;
      next_st.done = 1'b0;
      if (i_start) begin
         next_st.crc = i_cfg.seed & m;
         next_st.sh = '0;
      end else if (i_valid) begin
         next_st.sh = {st.sh[W+CRC_MAX-2:0], i_bit};
         if (i_cfg.len != 4'h0) begin
            fb = i_bit ^ st.crc[3'(i_cfg.len - 4'h1)];
            next_st.crc = ((st.crc << 1) ^ (fb ? i_cfg.poly : 8'h00)) & m;
         end
      end else if (i_fin) begin
         next_st.done = 1'b1;
         next_st.data = W'(st.sh >> i_cfg.len);
         next_st.ok = ((st.crc & m) == 8'h00);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_data = st.data;
   assign o_crc_ok = st.ok;
   assign o_done = st.done;
endmodule
`default_nettype wire

/* src/dsi_master_receive_check.sv */
// receive check, decision, loopback and fuse check for four bus channels
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - after reset copy 128 fuse bits, check parity, flag bit 7.
// - loopback only when both loop select bits are one.
// - in loopback the transmit stream replaces the received stream.
// - bus faults do not affect the looped test result.
// - entering loopback clears channel enable; host sets it again.
// - read-only buffer written in loopback only for matching patterns.
// - every message carries a crc; mismatch means invalid data.
// - default crc is 4 bits, polynomial 0x11, seed 1010.
// - crc length 0 to 8 bits, polynomial and seed per channel.
// - decision uses high line, low line and sum receivers.
// - all pass: flag equals high/low mismatch; ports get high, low.
// - high and sum pass, low fails: compare high with sum.
// - low and sum pass, high fails: compare low with sum.
// - only sum passes: flag clear, ports get both sum copies.
// - all other cases set flag and return high and low.
// - the two host port decision paths are fully separate; here each has its own sum copy but both share the high and low paths.
// - sum path keeps two duplicate holding registers.
// - transmit empty clears on select rise after write, sets when sent.
// - receive not empty sets on receive, clears on select rise after read.
module dsi_master_receive_check
   import dsi_rx_pkg::*;
#(
   parameter int N = NCH,
   parameter int W = MSG_W,
   parameter logic [6:0] MASK_REV = MASK_REV_DEF // arbitrary value
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire lane_t [N-1:0] i_lane,
   input wire crc_cfg_t [N-1:0] i_crc_cfg,
   input wire logic [N-1:0] i_loop_select_low,
   input wire logic [N-1:0] i_loop_select_high,
   input wire logic [N-1:0] i_enable_set,
   input wire logic [N-1:0] i_enable_clr,
   input wire logic [N-1:0] i_tx_write,
   input wire logic [N-1:0] i_tx_sent,
   input wire logic [N-1:0] i_rx_read,
   input wire logic i_main_port_select,
   input wire logic [FUSE_N-1:0] i_fuse_bits,
   input wire logic i_fuse_parity,
   output logic [N-1:0][W-1:0] o_main_port_data,
   output logic [N-1:0][W-1:0] o_readonly_port_data,
   output logic [N-1:0] o_receive_error_flag,
   output logic [N-1:0] o_readonly_write,
   output logic [N-1:0] o_transmit_empty_flag,
   output logic [N-1:0] o_receive_not_empty_flag,
   output logic [N-1:0] o_channel_enable_register,
   output logic [N-1:0] o_loopback_active,
   output logic [N-1:0] o_bus_fault_status,
   output logic [7:0] o_mask_revision_register,
   output logic [FUSE_N-1:0] o_fuse_trim
);
   typedef struct packed {
      lane_t [N-1:0] s1;
      lane_t [N-1:0] s2;
      logic cs1;
      logic cs2;
      logic cs3;
      logic [N-1:0] loop;
      logic [N-1:0] en;
      logic [N-1:0] te;
      logic [N-1:0] receive_not_empty_flag;
      logic [N-1:0] tx_pend;
      logic [N-1:0] rd_pend;
      logic [N-1:0] err;
      logic [N-1:0] ro_wr;
      logic [N-1:0] fault;
      logic [N-1:0][W-1:0] main_d;
      logic [N-1:0][W-1:0] ro_d;
      fuse_st_t fst;
      logic [FUSE_N-1:0] fuse;
      logic [7:0] mrev;
      crc_cfg_t [N-1:0] cfg;
   } top_st_t;

   top_st_t st;
   top_st_t next_st;

   logic [N-1:0][NPATH-1:0] pbit;
   logic [N-1:0][NPATH-1:0] pok;
   logic [N-1:0][NPATH-1:0] pdone;
   logic [N-1:0][NPATH-1:0][W-1:0] pdata;

   if (N < 1) begin : g_chk_n
      $error("dsi_master_receive_check: channel count must be positive");
   end
   if (W < ADDR_LSB + ADDR_W || W < DATA_LSB + DATA_W) begin : g_chk
      $error("dsi_master_receive_check: message width too small");
   end

   ////////////////////////////////////////////////////////////////////////
   // decision table, used once per host port path

   function automatic dec_t decide(input logic ok_h, input logic ok_l,
                                   input logic ok_s, input logic eq_hl,
                                   input logic eq_hs, input logic eq_ls);
      dec_t d;
      d = '{err: 1'b1, main_sum: 1'b0, ro_sum: 1'b0};
      if (ok_h && ok_l && ok_s) begin
         d.err = !eq_hl;
      end else if (ok_h && ok_s && !ok_l) begin
         if (eq_hs) begin
            d = '{err: 1'b0, main_sum: 1'b0, ro_sum: 1'b1};
         end
      end else if (ok_l && ok_s && !ok_h) begin
         if (eq_ls) begin
            d = '{err: 1'b0, main_sum: 1'b1, ro_sum: 1'b0};
         end
      end else if (ok_s && !ok_h && !ok_l) begin
         d = '{err: 1'b0, main_sum: 1'b1, ro_sum: 1'b1};
      end
      return d;
   endfunction

   function automatic logic loop_pattern(input logic [W-1:0] m);
      logic [DATA_W-1:0] d;
      logic [ADDR_W-1:0] a;
      d = m[DATA_LSB +: DATA_W];
      a = m[ADDR_LSB +: ADDR_W];
      return ((d == ADDR_ALL1) || (d == ADDR_ALL0)) && (a == ~d);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // receive paths: high, low and two duplicate sum copies per channel

   for (genvar c = 0; c < N; c++) begin : g_ch
      always_comb begin
         if (st.loop[c]) begin
            pbit[c] = {NPATH{st.s2[c].tx}};
         end else begin
            pbit[c] = {st.s2[c].sum, st.s2[c].sum,
                       st.s2[c].low, st.s2[c].high};
         end
      end
      for (genvar p = 0; p < NPATH; p++) begin : g_path
         rx_crc_path #(
            .W(W)
         ) u_path (
            .i_clk_sys(i_clk_sys),
            .i_sys_rst(i_sys_rst),
            .i_start(st.s2[c].start),
            .i_valid(st.s2[c].valid),
            .i_fin(st.s2[c].fin),
            .i_bit(pbit[c][p]),
            .i_cfg(st.cfg[c]),
            .o_data(pdata[c][p]),
            .o_crc_ok(pok[c][p]),
            .o_done(pdone[c][p])
         );
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      dec_t dm;
      dec_t dr;
      logic cs_rise;
      logic lp;
      logic [W-1:0] h;
      logic [W-1:0] l;
      logic [W-1:0] s0;
      logic [W-1:0] s1;
      logic [W-1:0] main_val;
      logic [W-1:0] ro_val;
      dm = '0;
      dr = '0;
      cs_rise = 1'b0;
      lp = 1'b0;
      h = '0;
      l = '0;
      s0 = '0;
      s1 = '0;
      main_val = '0;
      ro_val = '0;

      next_st = st;
      next_st.cfg = i_crc_cfg;
      // two-flop synchronisers for lane pins and select
      next_st.s1 = i_lane;
      next_st.s2 = st.s1;
      next_st.cs1 = i_main_port_select;
      next_st.cs2 = st.cs1;
      next_st.cs3 = st.cs2;
      cs_rise = st.cs2 && !st.cs3;
      next_st.ro_wr = '0;

      // fuse copy and parity check, once after reset
      case (st.fst)
         FS_LOAD: begin
            next_st.fuse = i_fuse_bits;
            next_st.mrev[PARITY_ERR_BIT] =
               ^{i_fuse_bits, i_fuse_parity};
            next_st.fst = FS_DONE;
         end
         FS_DONE: begin
            next_st.fst = FS_DONE;
         end
         default: begin
            next_st.fst = FS_LOAD;
         end
      endcase

      for (int c = 0; c < N; c++) begin
         // loopback select, fault mask and enable
         lp = i_loop_select_low[c] && i_loop_select_high[c];
         next_st.loop[c] = lp;
         next_st.fault[c] = st.s2[c].fault && !st.loop[c];

         if (lp && !st.loop[c]) begin
            next_st.en[c] = 1'b0;
         end else if (i_enable_set[c]) begin
            next_st.en[c] = 1'b1;
         end else if (i_enable_clr[c]) begin
            next_st.en[c] = 1'b0;
         end

         // transmit empty and receive not empty
         if (i_tx_write[c]) begin
            next_st.tx_pend[c] = 1'b1;
         end
         if (cs_rise && st.tx_pend[c]) begin
            next_st.te[c] = 1'b0;
            next_st.tx_pend[c] = i_tx_write[c];
         end
         if (i_tx_sent[c]) begin
            next_st.te[c] = 1'b1;
         end

         if (i_rx_read[c]) begin
            next_st.rd_pend[c] = 1'b1;
         end
         if (cs_rise && st.rd_pend[c]) begin
            next_st.receive_not_empty_flag[c] = 1'b0;
            next_st.rd_pend[c] = i_rx_read[c];
         end

         // receive decision, one path per host port
         h = pdata[c][P_HIGH];
         l = pdata[c][P_LOW];
         s0 = pdata[c][P_SUM0];
         s1 = pdata[c][P_SUM1];
         // main port path sees only high, low and the first sum copy
         dm = decide(pok[c][P_HIGH], pok[c][P_LOW], pok[c][P_SUM0],
                     h == l, h == s0, l == s0);
         // read-only port path sees only high, low and the second sum copy
         dr = decide(pok[c][P_HIGH], pok[c][P_LOW], pok[c][P_SUM1],
                     h == l, h == s1, l == s1);

         main_val = dm.main_sum ? s0 : h;
         ro_val = dr.ro_sum ? s1 : l;
         if (pdone[c][P_HIGH]) begin
            next_st.err[c] = dm.err;
            next_st.main_d[c] = main_val;
            next_st.receive_not_empty_flag[c] = 1'b1;
            if (!st.loop[c] || loop_pattern(ro_val)) begin
               next_st.ro_d[c] = ro_val;
               next_st.ro_wr[c] = 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         st <= '0;
         st.te <= '1;
         st.fst <= FS_LOAD;
         st.mrev <= {1'b0, MASK_REV};
         st.cs1 <= 1'b1;
         st.cs2 <= 1'b1;
         st.cs3 <= 1'b1;
         st.cfg <= {N{DEF_CRC_LEN, DEF_POLY, DEF_SEED}};
      end else begin
         st <= next_st;
      end
   end

   assign o_main_port_data = st.main_d;
   assign o_readonly_port_data = st.ro_d;
   assign o_receive_error_flag = st.err;
   assign o_readonly_write = st.ro_wr;
   assign o_transmit_empty_flag = st.te;
   assign o_receive_not_empty_flag = st.receive_not_empty_flag;
   assign o_channel_enable_register = st.en;
   assign o_loopback_active = st.loop;
   assign o_bus_fault_status = st.fault;
   assign o_mask_revision_register = st.mrev;
   assign o_fuse_trim = st.fuse;
endmodule
`default_nettype wire

/* testbench/rx_check_monitor.sv */
// assertion checker for the receive check block
`timescale 1ns/10ps
`default_nettype none
module rx_check_monitor
   import dsi_rx_pkg::*;
#(
   parameter int N = NCH,
   parameter int W = MSG_W,
   parameter logic [6:0] MASK_REV = MASK_REV_DEF
) (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire lane_t [N-1:0] i_lane,
   input wire logic [N-1:0] i_loop_select_low,
   input wire logic [N-1:0] i_loop_select_high,
   input wire logic [N-1:0] i_tx_sent,
   input wire logic [FUSE_N-1:0] i_fuse_bits,
   input wire logic i_fuse_parity,
   input wire logic [N-1:0][W-1:0] o_main_port_data,
   input wire logic [N-1:0][W-1:0] o_readonly_port_data,
   input wire logic [N-1:0] o_receive_error_flag,
   input wire logic [N-1:0] o_readonly_write,
   input wire logic [N-1:0] o_transmit_empty_flag,
   input wire logic [N-1:0] o_channel_enable_register,
   input wire logic [N-1:0] o_loopback_active,
   input wire logic [N-1:0] o_bus_fault_status,
   input wire logic [7:0] o_mask_revision_register,
   input wire logic [FUSE_N-1:0] o_fuse_trim
);
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_sys_rst);
   ////////////////////////////////////////////////////////////////////////
   chk_loop_select: assert property (
      !$past(i_sys_rst) |-> o_loopback_active ==
      $past(i_loop_select_low & i_loop_select_high))
      else $error("loopback state does not follow select bits");
   chk_entry_clear: assert property (
      (o_loopback_active & ~$past(o_loopback_active) &
      o_channel_enable_register) == '0)
      else $error("enable still set on loopback entry");
   chk_fault_mask: assert property (
      (o_loopback_active & $past(o_loopback_active) &
      o_bus_fault_status) == '0)
      else $error("bus fault visible in loopback");
   chk_mask_rev: assert property (
      o_mask_revision_register[6:0] == MASK_REV)
      else $error("revision field wrong");
   chk_fuse_parity: assert property (
      $fell(i_sys_rst) |=> o_fuse_trim == i_fuse_bits &&
      o_mask_revision_register[7] == ^{i_fuse_bits, i_fuse_parity})
      else $error("fuse copy or parity flag wrong");
   chk_te_sent: assert property (
      ($past(i_tx_sent) & ~o_transmit_empty_flag) == '0)
      else $error("transmit empty not set after send");
   for (genvar g = 0; g < N; g++) begin : gch
      chk_ro_pattern: assert property (
         o_readonly_write[g] && o_loopback_active[g] |->
         o_readonly_port_data[g][15:8] == ~o_readonly_port_data[g][7:0] &&
         (o_readonly_port_data[g][7:0] inside {8'h00, 8'hff}))
         else $error("read-only write in loopback with bad pattern");
      chk_update_fin: assert property (
         $changed(o_main_port_data[g]) || $changed(o_receive_error_flag[g])
         |-> $past(i_lane[g].fin, 4) || $past(i_lane[g].fin, 5) ||
         $past(i_lane[g].fin, 6))
         else $error("receive result changed without frame end");
   end
endmodule
bind dsi_master_receive_check rx_check_monitor #(
   .N(N), .W(W), .MASK_REV(MASK_REV)) mon (
   .i_clk_sys, .i_sys_rst, .i_lane, .i_loop_select_low,
   .i_loop_select_high, .i_tx_sent, .i_fuse_bits, .i_fuse_parity,
   .o_main_port_data, .o_readonly_port_data, .o_receive_error_flag,
   .o_readonly_write, .o_transmit_empty_flag, .o_channel_enable_register,
   .o_loopback_active, .o_bus_fault_status, .o_mask_revision_register,
   .o_fuse_trim);
`default_nettype wire

/* testbench/sensor_slave_model.sv */
// sensor slave model driving the bus-side receive lanes
`timescale 1ns/10ps
`default_nettype none
module sensor_slave_model
   import dsi_rx_pkg::*;
(
   input wire logic i_clk_sys,
   output var lane_t [NCH-1:0] o_lane
);
   logic [NCH-1:0] joined = '0;
   initial o_lane = '0;
   function automatic logic [7:0] crc_rem(logic [15:0] d, crc_cfg_t c);
      logic [7:0] r;
      logic fb;
      if (c.len == 4'h0) return 8'h00;
      r = c.seed;
      for (int i = 15; i >= 0; i--) begin
         fb = r[c.len-1] ^ d[i];
         r = {r[6:0], 1'b0} ^ (fb ? c.poly : 8'h00);
      end
      return r & 8'((9'h1 << c.len) - 9'h1);
   endfunction
   task automatic send_frame(input int ch, input logic [15:0] h, l, s,
         input logic [2:0] bad, input logic lp, input crc_cfg_t c);
      logic [23:0] fh, fl, fs;
      int n;
      n = 16 + int'(c.len);
      // first command seen acts as the initialization of this slave
      if (!joined[ch]) joined[ch] = 1'b1;
      fh = {h, crc_rem(h, c) << (8 - c.len)} ^ (24'(bad[2]) << (24 - n));
      fl = {l, crc_rem(l, c) << (8 - c.len)} ^ (24'(bad[1]) << (24 - n));
      fs = {s, crc_rem(s, c) << (8 - c.len)} ^ (24'(bad[0]) << (24 - n));
      @(negedge i_clk_sys);
      o_lane[ch].start = 1'b1;
      for (int j = 0; j < n; j++) begin
         @(negedge i_clk_sys);
         o_lane[ch].start = 1'b0;
         o_lane[ch].valid = 1'b1;
         o_lane[ch].high = fh[23-j] ^ lp;
         o_lane[ch].low = fl[23-j] ^ lp;
         o_lane[ch].sum = fs[23-j] ^ lp;
         o_lane[ch].tx = fh[23-j] ^ !lp;
         o_lane[ch].fault = lp;
      end
      @(negedge i_clk_sys);
      o_lane[ch].valid = 1'b0;
      o_lane[ch].fin = 1'b1;
      @(negedge i_clk_sys);
      o_lane[ch].fin = 1'b0;
      o_lane[ch].high = ~o_lane[ch].high;
      o_lane[ch].low = ~o_lane[ch].low;
      o_lane[ch].sum = ~o_lane[ch].sum;
      o_lane[ch].tx = ~o_lane[ch].tx;
   endtask
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking testbench for the receive check block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   import dsi_rx_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_sys_rst = 1'b1;
   lane_t [NCH-1:0] lane;
   crc_cfg_t [NCH-1:0] cfg;
   logic [NCH-1:0] sl = '0, sh = '0, es = '0, ec = '0, tw = '0, ts = '0;
   logic [NCH-1:0] rr = '0, er, rw, te, receive_not_empty_flag, en, lp, fl;
   logic [NCH-1:0][15:0] md, rd;
   logic cs = 1'b1, fpar = 1'b0;
   logic [127:0] fuse = '0, tr;
   logic [7:0] mr;
   logic [15:0] seed = 16'h004b;
   int err_total = 0, cmp_count = 0, ro_cnt = 0;
   sensor_slave_model slave (.i_clk_sys, .o_lane(lane));
   dsi_master_receive_check uut (.i_clk_sys, .i_sys_rst, .i_lane(lane),
      .i_crc_cfg(cfg), .i_loop_select_low(sl), .i_loop_select_high(sh),
      .i_enable_set(es), .i_enable_clr(ec), .i_tx_write(tw), .i_tx_sent(ts),
      .i_rx_read(rr), .i_main_port_select(cs), .i_fuse_bits(fuse),
      .i_fuse_parity(fpar), .o_main_port_data(md), .o_readonly_port_data(rd),
      .o_receive_error_flag(er), .o_readonly_write(rw),
      .o_transmit_empty_flag(te), .o_receive_not_empty_flag(receive_not_empty_flag),
      .o_channel_enable_register(en), .o_loopback_active(lp),
      .o_bus_fault_status(fl), .o_mask_revision_register(mr),
      .o_fuse_trim(tr));
   initial begin
      forever #50 i_clk_sys = ~i_clk_sys;
   end
   always @(posedge i_clk_sys) ro_cnt <= ro_cnt + $countones(rw);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed;
   endfunction
   function automatic logic [32:0] decide(logic [2:0] ok,
         logic [15:0] h, l, s);
      case (ok)
         3'b111: return {h !== l, h, l};
         3'b101: return (h === s) ? {1'b0, h, s} : {1'b1, h, l};
         3'b011: return (l === s) ? {1'b0, s, l} : {1'b1, h, l};
         3'b001: return {1'b0, s, s};
         default: return {1'b1, h, l};
      endcase
   endfunction
   task automatic chk_bit(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_word(input string nm, input logic [15:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk_sys);
   endtask
   task automatic sel_rise();
      cs = 1'b0;
      cyc(2);
      cs = 1'b1;
      cyc(6);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #3000000;
      err_total++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [15:0] h, l, s, d;
      logic [32:0] x;
      logic [2:0] ok;
      int ch, c0;
      cfg = {NCH{DEF_CRC_LEN, DEF_POLY, DEF_SEED}};
      for (int i = 0; i < 8; i++) begin
         fuse[16*i +: 16] = rnd();
      end
      fpar = seed[3];
      cfg[3] = {4'h8, rnd()};
      cfg[2].len = 4'h0;
      cyc(20);
      i_sys_rst = 1'b0;
      cyc(3);
      chk_bit("fuse parity", ^{fuse, fpar}, mr[7]);
      chk_bit("fuse copy", 1'b1, tr === fuse);
      chk_bit("reset flags", 1'b1, te === '1 && receive_not_empty_flag === '0 && en === '0);
      $display("test reset done");
      for (int k = 0; k < 32; k++) begin
         ch = k[4] ? 3 : 0;
         ok = k[2:0];
         h = rnd();
         l = (k[4:3] == 2'b00) ? h : ~h;
         s = (k[4:3] == 2'b01) ? h ^ 16'h00f0 : (k[4:3] == 2'b11) ? ~h : h;
         slave.send_frame(ch, h, l, s, ~ok, 1'b0, cfg[ch]);
         cyc(6);
         x = decide(ok, h, l, s);
         chk_bit("error flag", x[32], er[ch]);
         chk_word("main data", x[31:16], md[ch]);
         chk_word("readonly data", x[15:0], rd[ch]);
      end
      d = rnd();
      slave.send_frame(2, d, d, d, 3'b000, 1'b0, cfg[2]);
      cyc(6);
      chk_word("zero length crc", d, md[2]);
      $display("test decision done");
      chk_bit("receive not empty", 1'b1, receive_not_empty_flag[0]);
      tw[0] = 1'b1;
      cyc(1);
      tw[0] = 1'b0;
      sel_rise();
      chk_bit("transmit empty", 1'b0, te[0]);
      ts[0] = 1'b1;
      rr[0] = 1'b1;
      cyc(1);
      ts[0] = 1'b0;
      rr[0] = 1'b0;
      cyc(1);
      chk_bit("transmit empty", 1'b1, te[0]);
      sel_rise();
      chk_bit("transmit empty", 1'b1, te[0]);
      chk_bit("receive not empty", 1'b0, receive_not_empty_flag[0]);
      $display("test status done");
      sl[1] = 1'b1;
      es[1] = 1'b1;
      cyc(1);
      es[1] = 1'b0;
      cyc(2);
      chk_bit("loop half select", 1'b0, lp[1]);
      chk_bit("enable", 1'b1, en[1]);
      sh[1] = 1'b1;
      cyc(3);
      chk_bit("loop select", 1'b1, lp[1]);
      chk_bit("enable", 1'b0, en[1]);
      for (int k = 0; k < 4; k++) begin
         d = (k == 0) ? 16'h00ff : (k == 1) ? 16'hff00 : rnd();
         c0 = ro_cnt;
         slave.send_frame(1, d, d, d, 3'b000, 1'b1, cfg[1]);
         cyc(6);
         chk_word("loop data", d, md[1]);
         chk_bit("loop error", 1'b0, er[1]);
         chk_bit("loop fault", 1'b0, fl[1]);
         chk_bit("ro write", k < 2, ro_cnt - c0 == 1);
      end
      es[1] = 1'b1;
      cyc(1);
      es[1] = 1'b0;
      cyc(2);
      chk_bit("enable", 1'b1, en[1]);
      ec[1] = 1'b1;
      cyc(1);
      ec[1] = 1'b0;
      cyc(2);
      chk_bit("enable", 1'b0, en[1]);
      $display("test loopback done");
      fpar = ~fpar;
      i_sys_rst = 1'b1;
      cyc(20);
      i_sys_rst = 1'b0;
      cyc(3);
      chk_bit("fuse parity", ^{fuse, fpar}, mr[7]);
      chk_bit("reset flags", 1'b1, te === '1 && receive_not_empty_flag === '0 && en === '0);
      $display("test second reset done");
      final_report();
   end
endmodule
`default_nettype wire
